// ==== rtl/qpd_pkg.sv ====
// Constants, types and helpers shared by the quad predriver serial fault controller
// Function
// - Chip select falling enables serial output, captures fault bits, refreshes fault flag.
// - While chip select low, serial input is sampled on each serial clock rise.
// - A latched control one turns its gate on, a zero turns it off.
// - Captured fault bits, one per channel, shift out while input bits shift in.
// - A one in the fault data means that channel has a fault.
// - Faults follow hardware; only those present at chip select fall are captured. Shutdown variant holds a confirmed short until chip select rise.
// - Chip select rise latches last four bits, tri-states output, re-arms fault register.
// - Received bits pass out on serial output after own fault bits.
// - Each parallel input drives its gate without chip select or serial clock.
// - Gate on when serial control bit or parallel input is high.
// - Drain compare: short detected while on, open load while off.
// - Strap low selects internal reference, strap high selects external reference.
// - Shutdown variant: confirmed short turns channel off and reports it.
// - PWM variant: confirmed short drives low-duty PWM while fault persists.
// - Short flagged only after persisting for the deglitch interval.
// - Battery fault disables all channels, asserts flag, not in serial data.
// - Battery fault suppresses load fault reporting until it clears.
// - Active-low reset clears registers and flags and turns gates off.
// - Open-drain active-low fault flag asserts in real time for any fault.
package qpd_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int NUM_CH = 4;

  // Short deglitch: least time, rounded up
  localparam int SHORT_DEGLITCH_TIME_NS = 10000;
  localparam int SHORT_DEGLITCH_INT = (SHORT_DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_DEGLITCH_W = 10;
  localparam logic [SHORT_DEGLITCH_W-1:0] SHORT_DEGLITCH_CYCLES = SHORT_DEGLITCH_W'(SHORT_DEGLITCH_INT);

  // Fault-mode PWM: period and on time, longest times rounded down
  localparam int PWM_PERIOD_TIME_NS = 20000;
  localparam int PWM_ON_TIME_NS = 1000;
  localparam int PWM_W = 11;
  localparam logic [PWM_W-1:0] PWM_PERIOD_CYCLES = PWM_W'(PWM_PERIOD_TIME_NS / CLK_PERIOD_NS);
  localparam logic [PWM_W-1:0] PWM_ON_CYCLES = PWM_W'(PWM_ON_TIME_NS / CLK_PERIOD_NS);

  // Reset values
  localparam logic [NUM_CH-1:0] CTRL_RESET = 4'h0;
  localparam logic [NUM_CH-1:0] FAULT_RESET = 4'h0;
  localparam logic [NUM_CH-1:0] GATE_RESET = 4'h0;

  // Width of the synchronised pin bundle
  localparam int SYNC_W = 16;
  // Synchroniser reset: chip select at its idle high level, all else low
  localparam logic [SYNC_W-1:0] SYNC_RESET = 16'h8000;

  typedef enum logic [1:0] {
    QPD_IDLE = 2'b01,
    QPD_FRAME = 2'b10
  } qpd_frame_t;

  // Shift one serial bit in at the low end
  function automatic logic [NUM_CH-1:0] qpd_shift_in(input logic [NUM_CH-1:0] cur, input logic inBit);
    qpd_shift_in = {cur[NUM_CH-2:0], inBit};
  endfunction : qpd_shift_in

endpackage : qpd_pkg

// ==== rtl/qpd_link_if.sv ====
// Signals between the core clock domain and the serial-clock shifter
`timescale 1ns/100ps
interface qpd_link_if;
  import qpd_pkg::*;
  logic [NUM_CH-1:0] faultSnap;
  logic [NUM_CH-1:0] shiftData;
  modport core (output faultSnap, input shiftData);
  modport link (input faultSnap, output shiftData);
endinterface : qpd_link_if

// ==== rtl/qpd_link_shifter.sv ====
// Serial shift register running on the host serial clock
`timescale 1ns/100ps
module qpd_link_shifter
  import qpd_pkg::*;
(
  input wire logic sclk,
  input wire logic rstN,
  input wire logic csN,
  input wire logic sdi,
  output logic sdoBit,
  qpd_link_if.link lnk
);

  logic [NUM_CH-1:0] shiftBits_reg;
  logic [NUM_CH-1:0] shiftBits_next;
  logic firstDone_reg;
  logic firstDone_next;
  logic frameRstN;

  // Frame flag clears whenever chip select is high, so each frame restarts from the snapshot
  assign frameRstN = rstN & ~csN;

  // Next shift value; the snapshot is stable while chip select is low
  always_comb
  begin
    shiftBits_next = shiftBits_reg;
    firstDone_next = firstDone_reg;
    if (!csN)
    begin
      firstDone_next = 1'b1;
      if (firstDone_reg)
        shiftBits_next = qpd_shift_in(shiftBits_reg, sdi);
      else
        shiftBits_next = qpd_shift_in(lnk.faultSnap, sdi);
    end
  end

  // Shift register keeps its contents past chip select rise for the core to copy
  always_ff @(posedge sclk or negedge rstN)
  begin
    if (!rstN)
      shiftBits_reg <= CTRL_RESET;
    else
      shiftBits_reg <= shiftBits_next;
  end

  // First-edge flag
  always_ff @(posedge sclk or negedge frameRstN)
  begin
    if (!frameRstN)
      firstDone_reg <= 1'b0;
    else
      firstDone_reg <= firstDone_next;
  end

  // Before the first edge the top fault bit is presented directly
  assign sdoBit = firstDone_reg ? shiftBits_reg[NUM_CH-1] : lnk.faultSnap[NUM_CH-1];
  assign lnk.shiftData = shiftBits_reg;

  chk_first_load: assert property (@(posedge sclk) disable iff (!rstN || csN)
    $rose(firstDone_reg) |-> shiftBits_reg[NUM_CH-1:1] == $past(lnk.faultSnap[NUM_CH-2:0]))
    else $error("first shift did not load fault snapshot");
  chk_shift_walk: assert property (@(posedge sclk) disable iff (!rstN || csN)
    firstDone_reg && $past(firstDone_reg) |-> shiftBits_reg[NUM_CH-1:1] == $past(shiftBits_reg[NUM_CH-2:0]))
    else $error("serial data did not shift through");

endmodule : qpd_link_shifter

// ==== rtl/qpd_core.sv ====
// Quad predriver serial control, fault detection and gate drive top level
`timescale 1ns/100ps
module qpd_core
  import qpd_pkg::*;
#(
  parameter bit PWM_ON_SHORT = 1'b0
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic powerOnResetN,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  input wire logic [NUM_CH-1:0] parallelChannelIn,
  input wire logic [NUM_CH-1:0] drainSenseInt,
  input wire logic [NUM_CH-1:0] drainSenseExt,
  input wire logic extRefSelect,
  input wire logic overVoltage,
  input wire logic underVoltage,
  output logic [NUM_CH-1:0] gateOut,
  input wire logic faultFlagNIn,
  output logic faultFlagNOut,
  output logic faultFlagNOe
);

  logic rstN;
  logic [SYNC_W-1:0] rawPins;
  logic [SYNC_W-1:0] syncA_reg;
  logic [SYNC_W-1:0] syncA_next;
  logic [SYNC_W-1:0] syncB_reg;
  logic [SYNC_W-1:0] syncB_next;
  logic csLow;
  logic batteryNow;
  logic extRefNow;
  logic [NUM_CH-1:0] parIn;
  logic [NUM_CH-1:0] senseInt;
  logic [NUM_CH-1:0] senseExt;
  qpd_frame_t frameState_reg;
  qpd_frame_t frameState_next;
  logic csFall;
  logic csRise;
  logic [NUM_CH-1:0] ctrl_reg;
  logic [NUM_CH-1:0] ctrl_next;
  logic [NUM_CH-1:0] faultSnap_reg;
  logic [NUM_CH-1:0] faultSnap_next;
  logic [NUM_CH-1:0] gate_reg;
  logic [NUM_CH-1:0] gate_next;
  logic [NUM_CH-1:0] shortLatched_reg;
  logic [NUM_CH-1:0] shortLatched_next;
  logic [SHORT_DEGLITCH_W-1:0] dgCnt_reg [NUM_CH];
  logic [SHORT_DEGLITCH_W-1:0] dgCnt_next [NUM_CH];
  logic [PWM_W-1:0] pwmCnt_reg;
  logic [PWM_W-1:0] pwmCnt_next;
  logic pwmHigh;
  logic [NUM_CH-1:0] drainHigh;
  logic [NUM_CH-1:0] gateCmd;
  logic [NUM_CH-1:0] shortCand;
  logic [NUM_CH-1:0] shortConfirm;
  logic [NUM_CH-1:0] openNow;
  logic [NUM_CH-1:0] faultLive;
  logic flagOe_reg;
  logic flagOe_next;
  logic sdoOe_reg;
  logic sdoOe_next;

  // Carrier for the words that cross between the two clock domains
  qpd_link_if lnk ();

  // Power-on reset and external reset share one path
  assign rstN = resetn & powerOnResetN;

  // Pins from outside this clock domain, bundled for a two-stage synchroniser
  assign rawPins = {csN, overVoltage, underVoltage, extRefSelect, parallelChannelIn, drainSenseInt, drainSenseExt};

  // Second stage samples the first a full cycle later, giving it time to settle
  always_comb
  begin
    syncA_next = rawPins;
    syncB_next = syncA_reg;
  end

  // Reset holds chip select at its idle level so no false frame start follows reset
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      syncA_reg <= SYNC_RESET;
      syncB_reg <= SYNC_RESET;
    end
    else
    begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
    end
  end

  // Only the second stage is read
  assign csLow = ~syncB_reg[15];
  assign batteryNow = syncB_reg[14] | syncB_reg[13];
  assign extRefNow = syncB_reg[12];
  assign parIn = syncB_reg[11:8];
  assign senseInt = syncB_reg[7:4];
  assign senseExt = syncB_reg[3:0];

  // Frame tracking on the synchronised chip select
  always_comb
  begin
    frameState_next = frameState_reg;
    csFall = 1'b0;
    csRise = 1'b0;
    unique case (frameState_reg)
      QPD_IDLE:
      begin
        if (csLow)
        begin
          csFall = 1'b1;
          frameState_next = QPD_FRAME;
        end
      end
      QPD_FRAME:
      begin
        if (!csLow)
        begin
          csRise = 1'b1;
          frameState_next = QPD_IDLE;
        end
      end
      default:
        frameState_next = QPD_IDLE;
    endcase
  end

  // Frame state register
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      frameState_reg <= QPD_IDLE;
    else
      frameState_reg <= frameState_next;
  end

  // Fault-mode PWM time base, free running so all channels share one phase
  always_comb
  begin
    if (pwmCnt_reg == PWM_PERIOD_CYCLES - 11'h001)
      pwmCnt_next = 11'h000;
    else
      pwmCnt_next = pwmCnt_reg + 11'h001;
  end

  assign pwmHigh = pwmCnt_reg < PWM_ON_CYCLES;

  // PWM counter register
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      pwmCnt_reg <= 11'h000;
    else
      pwmCnt_reg <= pwmCnt_next;
  end

  // Per-channel detection; comparator outputs are high when the drain sits above the reference
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      drainHigh[i] = extRefNow ? senseExt[i] : senseInt[i];
      gateCmd[i] = ctrl_reg[i] | parIn[i];
      shortCand[i] = gate_reg[i] & drainHigh[i] & ~batteryNow;
      openNow[i] = ~gate_reg[i] & ~drainHigh[i] & ~batteryNow;
    end
  end

  // Short deglitch counters, saturating one short of the interval
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      shortConfirm[i] = shortCand[i] && (dgCnt_reg[i] == SHORT_DEGLITCH_CYCLES - 10'h001);
      if (!shortCand[i])
        dgCnt_next[i] = 10'h000;
      else if (shortConfirm[i])
        dgCnt_next[i] = dgCnt_reg[i];
      else
        dgCnt_next[i] = dgCnt_reg[i] + 10'h001;
    end
  end

  // Deglitch counter registers
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      for (int i = 0; i < NUM_CH; i++)
        dgCnt_reg[i] <= 10'h000;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
        dgCnt_reg[i] <= dgCnt_next[i];
    end
  end

  // Short latch: a new confirmation wins over the re-arm at chip select rise
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (shortConfirm[i])
        shortLatched_next[i] = 1'b1;
      else if (csRise)
        shortLatched_next[i] = 1'b0;
      else if (PWM_ON_SHORT && gate_reg[i] && !drainHigh[i])
        shortLatched_next[i] = 1'b0;
      else
        shortLatched_next[i] = shortLatched_reg[i];
    end
  end

  // Gate drive; shutdown holds the channel off, PWM lets the low-duty pulse through
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (batteryNow)
        gate_next[i] = 1'b0;
      else if (shortLatched_reg[i])
        gate_next[i] = PWM_ON_SHORT ? (gateCmd[i] & pwmHigh) : 1'b0;
      else
        gate_next[i] = gateCmd[i];
    end
  end

  // Live fault view, masked by battery faults which never reach the serial data
  assign faultLive = batteryNow ? 4'h0 : (shortLatched_reg | openNow);

  // Snapshot and control latch at frame edges
  always_comb
  begin
    faultSnap_next = csFall ? faultLive : faultSnap_reg;
    ctrl_next = csRise ? lnk.shiftData : ctrl_reg;
    flagOe_next = (|faultLive) | batteryNow;
    sdoOe_next = csLow;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_reg <= CTRL_RESET;
      faultSnap_reg <= FAULT_RESET;
      gate_reg <= GATE_RESET;
      shortLatched_reg <= FAULT_RESET;
      flagOe_reg <= 1'b0;
      sdoOe_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      faultSnap_reg <= faultSnap_next;
      gate_reg <= gate_next;
      shortLatched_reg <= shortLatched_next;
      flagOe_reg <= flagOe_next;
      sdoOe_reg <= sdoOe_next;
    end
  end

  // The snapshot crosses as a word held stable for the whole frame
  assign lnk.faultSnap = faultSnap_reg;

  // Shifter runs on the host serial clock; only the snapshot and shift words cross
  qpd_link_shifter u_shifter (
    .sclk(sclk),
    .rstN(rstN),
    .csN(csN),
    .sdi(sdi),
    .sdoBit(sdo),
    .lnk(lnk)
  );

  // Open-drain flag only ever pulls low
  assign faultFlagNOut = 1'b0;
  assign faultFlagNOe = flagOe_reg;
  // Enables and gates are registered, so the pins never glitch
  assign sdoOe = sdoOe_reg;
  assign gateOut = gate_reg;

  // Frame edge checks
  chk_snap_on_fall: assert property (@(posedge clk) disable iff (!rstN)
    csFall |=> faultSnap_reg == $past(faultLive) && sdoOe_reg)
    else $error("fault snapshot or output enable missed at frame start");
  chk_snap_hold: assert property (@(posedge clk) disable iff (!rstN)
    (frameState_reg == QPD_FRAME && csLow) |=> $stable(faultSnap_reg))
    else $error("fault snapshot changed inside a frame");
  chk_ctrl_latch: assert property (@(posedge clk) disable iff (!rstN)
    csRise |=> ctrl_reg == $past(lnk.shiftData) && !sdoOe_reg)
    else $error("control bits not latched at frame end");
  chk_sdo_idle: assert property (@(posedge clk) disable iff (!rstN)
    (frameState_reg == QPD_IDLE && !csLow) |=> !sdoOe_reg)
    else $error("serial output enabled outside a frame");

  // Gate drive and fault checks
  chk_gate_or: assert property (@(posedge clk) disable iff (!rstN)
    (!batteryNow && shortLatched_reg == 4'h0) |=> gate_reg == $past(ctrl_reg | parIn))
    else $error("gate is not the OR of serial and parallel commands");
  chk_battery_off: assert property (@(posedge clk) disable iff (!rstN)
    batteryNow |=> gate_reg == 4'h0 && faultFlagNOe)
    else $error("battery fault did not disable gates and raise flag");
  chk_battery_mask: assert property (@(posedge clk) disable iff (!rstN)
    batteryNow |-> faultLive == 4'h0)
    else $error("load faults reported during battery fault");
  chk_short_deglitch: assert property (@(posedge clk) disable iff (!rstN)
    $rose(shortLatched_reg[0]) |-> $past(shortCand[0]) && $past(dgCnt_reg[0]) == SHORT_DEGLITCH_CYCLES - 10'h001)
    else $error("short latched before deglitch interval");
  chk_short_shutdown: assert property (@(posedge clk) disable iff (!rstN)
    (!PWM_ON_SHORT && shortLatched_reg[0]) |=> !gate_reg[0])
    else $error("shorted channel left on in shutdown variant");
  chk_flag_live: assert property (@(posedge clk) disable iff (!rstN)
    (|faultLive) |=> faultFlagNOe)
    else $error("fault flag not asserted for a live fault");
  chk_short_pwm: assert property (@(posedge clk) disable iff (!rstN)
    (PWM_ON_SHORT && shortLatched_reg[0] && !pwmHigh) |=> !gate_reg[0])
    else $error("shorted channel on outside the PWM on window");
  chk_flag_quiet: assert property (@(posedge clk) disable iff (!rstN)
    (!(|faultLive) && !batteryNow) |=> !faultFlagNOe)
    else $error("fault flag asserted with no fault present");
  chk_pwm_wrap: assert property (@(posedge clk) disable iff (!rstN)
    (pwmCnt_reg == PWM_PERIOD_CYCLES - 11'h001) |=> pwmCnt_reg == 11'h000)
    else $error("PWM time base did not wrap at its period");
  chk_deglitch_bound: assert property (@(posedge clk) disable iff (!rstN)
    dgCnt_reg[0] < SHORT_DEGLITCH_CYCLES)
    else $error("deglitch counter ran past its interval");

  // Main scenarios
  cov_frame_end: cover property (@(posedge clk) disable iff (!rstN) csRise);
  cov_pwm_pulse: cover property (@(posedge clk) disable iff (!rstN) PWM_ON_SHORT && shortLatched_reg[0] && gate_reg[0]);
  cov_short_found: cover property (@(posedge clk) disable iff (!rstN) |shortConfirm);
  cov_battery: cover property (@(posedge clk) disable iff (!rstN) batteryNow ##1 !batteryNow);
  cov_wired_flag: cover property (@(posedge clk) disable iff (!rstN) !faultFlagNOe && !faultFlagNIn);

endmodule : qpd_core

// ==== testbench/qpd_host_model.sv ====
// Host controller model driving the serial chip-select link
`timescale 1ns/100ps
module qpd_host_model
  import qpd_pkg::*;
(
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdoOe,
  output logic sclk,
  output logic csN,
  output logic sdi
);
  // Idle link: clock still, select released high, data pulled down
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end

  // One frame of n bits, first bit sent first; returns what sdo carried
  task automatic frame(input int n, input logic [7:0] dout, output logic [7:0] din);
    din = 8'h00;
    @(posedge clk);
    csN <= 1'b0;
    repeat (8) @(posedge clk); // Output enable must settle before first edge
    #7;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = dout[i];
      #32;
      din[i] = sdoOe ? sdo : 1'bx; // Undriven pin never counts as data
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
    end
    #32;
    sdi = 1'b0;
    @(posedge clk);
    csN <= 1'b1;
    repeat (8) @(posedge clk); // Control latch completes before next frame
  endtask : frame
endmodule : qpd_host_model

// ==== testbench/quad_predriver_serial_fault_ctrl_tb.sv ====
// Self-checking bench for the quad predriver serial fault controller
`timescale 1ns/100ps
`define QPD_CHECK(act, exp) \
  begin \
    checks++; \
    if ((act) !== (exp)) \
    begin \
      numErrors++; \
      $display("ERROR at %0t: got %h expected %h", $time, act, exp); \
    end \
  end
module quad_predriver_serial_fault_ctrl_tb;
  import qpd_pkg::*;
  logic clk;
  logic resetn;
  logic powerOnResetN;
  logic sclk;
  logic csN;
  logic sdi;
  logic sdo;
  logic sdoOe;
  logic [3:0] parallelChannelIn;
  logic [3:0] drainSenseInt;
  logic [3:0] drainSenseExt;
  logic extRefSelect;
  logic overVoltage;
  logic underVoltage;
  logic [3:0] gateOut;
  logic faultFlagNIn;
  logic faultFlagNOut;
  logic faultFlagNOe;
  logic [3:0] gateOutPwm;
  logic faultFlagNOutPwm;
  logic faultFlagNOePwm;
  logic [PWM_W-1:0] pwmOn;
  logic [3:0] shortMask;
  logic [3:0] openMask;
  logic [3:0] openExt;
  logic [7:0] rx;
  int numErrors;
  int checks;

  qpd_core #(.PWM_ON_SHORT(1'b0)) u_dut (.clk(clk), .resetn(resetn), .powerOnResetN(powerOnResetN),
    .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .parallelChannelIn(parallelChannelIn),
    .drainSenseInt(drainSenseInt), .drainSenseExt(drainSenseExt), .extRefSelect(extRefSelect),
    .overVoltage(overVoltage), .underVoltage(underVoltage), .gateOut(gateOut),
    .faultFlagNIn(faultFlagNIn), .faultFlagNOut(faultFlagNOut), .faultFlagNOe(faultFlagNOe));

  // Second copy in the PWM variant shares every input with the first
  qpd_core #(.PWM_ON_SHORT(1'b1)) u_dut_pwm (.clk(clk), .resetn(resetn), .powerOnResetN(powerOnResetN),
    .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(), .sdoOe(), .parallelChannelIn(parallelChannelIn),
    .drainSenseInt(drainSenseInt), .drainSenseExt(drainSenseExt), .extRefSelect(extRefSelect),
    .overVoltage(overVoltage), .underVoltage(underVoltage), .gateOut(gateOutPwm),
    .faultFlagNIn(faultFlagNIn), .faultFlagNOut(faultFlagNOutPwm), .faultFlagNOe(faultFlagNOePwm));

  qpd_host_model u_host (.clk(clk), .sdo(sdo), .sdoOe(sdoOe), .sclk(sclk), .csN(csN), .sdi(sdi));

  // Flag line has an external pull-up; any enabled driver pulls it low
  assign faultFlagNIn = ~((faultFlagNOe & ~faultFlagNOut) | (faultFlagNOePwm & ~faultFlagNOutPwm));

  // Load model: a gate that is on pulls its drain low; short holds it high, open lets it float low
  always @(posedge clk)
  begin
    drainSenseInt <= shortMask | (~gateOut & ~openMask);
    drainSenseExt <= shortMask | (~gateOut & ~openExt);
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Wait whole cycles, then step past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic endOfTest();
    $display("checks %0d errors %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : endOfTest

  // Watchdog sized well above the roughly 42 us the sequence needs
  initial
  begin
    #300000;
    numErrors++;
    endOfTest();
  end

  initial
  begin
    resetn = 1'b0;
    powerOnResetN = 1'b1;
    parallelChannelIn = 4'h0;
    extRefSelect = 1'b0;
    overVoltage = 1'b0;
    underVoltage = 1'b0;
    shortMask = 4'h0;
    openMask = 4'h0;
    openExt = 4'h0;
    numErrors = 0;
    checks = 0;
    tick(3);
    `QPD_CHECK({gateOut, sdoOe, faultFlagNOe}, 6'h00)
    @(posedge clk);
    resetn <= 1'b1;
    tick(4);
    // Each single channel, mixed patterns and all off through the serial link
    for (int k = 0; k < 8; k++)
    begin
      u_host.frame(4, {4'h0, 4'(k == 7 ? 0 : (k == 6 ? 15 : (k < 4 ? 1 << k : (k == 4 ? 5 : 10))))}, rx);
      `QPD_CHECK(gateOut, 4'(k == 7 ? 0 : (k == 6 ? 15 : (k < 4 ? 1 << k : (k == 4 ? 5 : 10)))))
      `QPD_CHECK(sdoOe, 1'b0)
    end
    // Open load on channel 1 is flagged live, read out, then clears once gone
    @(posedge clk);
    openMask <= 4'h2;
    openExt <= 4'h2;
    tick(8);
    `QPD_CHECK(faultFlagNIn, 1'b0)
    u_host.frame(4, 8'h00, rx);
    `QPD_CHECK(rx[3:0], 4'h2)
    @(posedge clk);
    openMask <= 4'h0;
    openExt <= 4'h0;
    tick(8);
    u_host.frame(4, 8'h00, rx);
    `QPD_CHECK(rx[3:0], 4'h0)
    `QPD_CHECK(faultFlagNOe, 1'b0)
    // Chained frame: own faults first, then the first four received bits
    u_host.frame(8, 8'hA5, rx);
    `QPD_CHECK(rx, 8'h0A)
    `QPD_CHECK(gateOut, 4'h5)
    // Parallel inputs combine with serial control bits
    u_host.frame(4, 8'h03, rx);
    @(posedge clk);
    parallelChannelIn <= 4'hC;
    tick(6);
    `QPD_CHECK(gateOut, 4'hF)
    u_host.frame(4, 8'h03, rx);
    `QPD_CHECK(rx[3:0], 4'h0)
    @(posedge clk);
    parallelChannelIn <= 4'h0;
    tick(6);
    `QPD_CHECK(gateOut, 4'h3)
    // External reference: only the selected comparator counts
    u_host.frame(4, 8'h00, rx);
    @(posedge clk);
    extRefSelect <= 1'b1;
    openMask <= 4'h4;
    tick(8);
    `QPD_CHECK(faultFlagNOe, 1'b0)
    u_host.frame(4, 8'h00, rx);
    `QPD_CHECK(rx[3:0], 4'h0)
    @(posedge clk);
    extRefSelect <= 1'b0;
    tick(8);
    u_host.frame(4, 8'h00, rx);
    `QPD_CHECK(rx[3:0], 4'h4)
    @(posedge clk);
    openMask <= 4'h0;
    // Short on channel 0: tolerated through the deglitch, then shut off
    u_host.frame(4, 8'h01, rx);
    @(posedge clk);
    shortMask <= 4'h1;
    tick(990);
    `QPD_CHECK({gateOut[0], faultFlagNOe}, 2'h2)
    tick(30);
    `QPD_CHECK({gateOut[0], faultFlagNOe}, 2'h1)
    `QPD_CHECK(faultFlagNOePwm, 1'b1)
    // PWM copy: one full period of fault-mode drive holds exactly the on time
    pwmOn = 11'h000;
    repeat (PWM_PERIOD_CYCLES)
    begin
      tick(1);
      pwmOn = pwmOn + PWM_W'(gateOutPwm[0]);
    end
    `QPD_CHECK(pwmOn, PWM_ON_CYCLES)
    u_host.frame(4, 8'h00, rx);
    `QPD_CHECK(rx[3:0], 4'h1)
    @(posedge clk);
    shortMask <= 4'h0;
    // Battery over- and undervoltage lock all gates and hide load faults
    for (int k = 0; k < 2; k++)
    begin
      u_host.frame(4, 8'h0F, rx);
      @(posedge clk);
      overVoltage <= (k == 0);
      underVoltage <= (k == 1);
      tick(6);
      `QPD_CHECK({gateOut, faultFlagNOe}, 5'h01)
      @(posedge clk);
      openMask <= 4'h2;
      tick(6);
      u_host.frame(4, 8'h0F, rx);
      `QPD_CHECK(rx[3:0], 4'h0)
      @(posedge clk);
      openMask <= 4'h0;
      tick(4);
      @(posedge clk);
      overVoltage <= 1'b0;
      underVoltage <= 1'b0;
      tick(8);
      `QPD_CHECK({gateOut, faultFlagNOe}, 5'h1E)
    end
    // Internal power-on reset clears like the external one
    @(posedge clk);
    powerOnResetN <= 1'b0;
    tick(2);
    `QPD_CHECK({gateOut, sdoOe, faultFlagNOe}, 6'h00)
    @(posedge clk);
    powerOnResetN <= 1'b1;
    tick(4);
    endOfTest();
  end
endmodule : quad_predriver_serial_fault_ctrl_tb
